/* hdl/sli_pkg.sv */
// Purpose: constants for the front panel status and channel indicator driver
// Assumes: pclk at 20 MHz, APB register access, 32-bit data
// Notes: mode codes come from the control logic
//
// Functional notes
// [RULE_01] power-on state blinks yellow at 1 Hz before start-up begins
// [RULE_02] start-up blinks green at 2 Hz for at least 3 s
// [RULE_03] STOP with nothing else pending lights yellow steadily
// [RULE_04] RUN without error or warning lights green steadily
// [RULE_05] RUN with error or warning: red blinks 1 Hz, green steady
// [RULE_06] holding point reached: red steady, green blinks 1 Hz
// [RULE_07] diagnostics during start-up: red blinks 1 Hz, green blinks 2 Hz
// [RULE_08] error lights red; system or internal error lights red and yellow
// [RULE_09] hardware configuration loading blinks yellow at 2 Hz
// [RULE_10] blink test request blinks green at 1 Hz while requested
// [RULE_11] card access in RUN flickers green; with error red blinks 1 Hz
// [RULE_12] card access in STOP flickers yellow
// [RULE_13] overall reset: yellow 1 Hz requested, 2 Hz executing, steady when done
// [RULE_14] factory reset: yellow 2 Hz executing, red and yellow 1 Hz when done
// [RULE_15] new firmware found: red and yellow blink 1 Hz in opposite phase
// [RULE_16] firmware update: yellow 2 Hz, flicker on card, then done or fail
// [RULE_17] each digital input LED follows its input level, sixteen inputs
// [RULE_18] each digital output LED follows its driven output, twelve outputs
// [RULE_19] input supply LED lit while input section supply is good
// [RULE_20] output supply LED lit while output section supply is good
// [RULE_21] output fault LED lit while overload or short is flagged
// [RULE_22] each analog channel LED lit while signal is out of range
// [RULE_23] network link LED lit on link, blinks on traffic, speed LED on 100M
// [RULE_24] all blink and flicker phases come from one shared divider
// [RULE_25] priority: sequences, then errors, then card access, then RUN or STOP
package sli_pkg;
    // -------------------------------------------------------------------
    // timing
    // -------------------------------------------------------------------
    localparam int CLK_KHZ = 20000;
    localparam int FLICKER_HALF_MS = 50;
    localparam int BLINK_2HZ_HALF_MS = 250;
    localparam int STARTUP_MIN_MS = 3000;
    localparam int FLICKER_HALF_CYCLES = FLICKER_HALF_MS * CLK_KHZ;
    localparam int FLICKS_PER_HALF = BLINK_2HZ_HALF_MS / FLICKER_HALF_MS;
    localparam int STARTUP_TICKS = STARTUP_MIN_MS / FLICKER_HALF_MS;
    localparam int TB_CNT_W = 32;
    localparam int FLK_CNT_W = 3;
    localparam int STARTUP_CNT_W = 7;
    // -------------------------------------------------------------------
    // register map
    // -------------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [11:0] ADDR_MODE = 12'h000;
    localparam logic [11:0] ADDR_FLAGS = 12'h004;
    localparam logic [11:0] ADDR_LED = 12'h008;
    localparam logic [11:0] ADDR_INPUT = 12'h00C;
    localparam int MODE_W = 5;
    localparam int FLAGS_W = 4;
    localparam int FLAG_ERRWARN = 0;
    localparam int FLAG_CARD = 1;
    localparam int FLAG_BLINKTEST = 2;
    localparam int FLAG_DIAG = 3;
    localparam logic [3:0] FLAGS_RESET = 4'h0;
    // -------------------------------------------------------------------
    // operating mode codes
    // -------------------------------------------------------------------
    localparam logic [4:0] MODE_POWER_ON = 5'h00;
    localparam logic [4:0] MODE_STARTUP = 5'h01;
    localparam logic [4:0] MODE_RUN = 5'h02;
    localparam logic [4:0] MODE_STOP = 5'h03;
    localparam logic [4:0] MODE_ERROR = 5'h04;
    localparam logic [4:0] MODE_SYS_ERROR = 5'h05;
    localparam logic [4:0] MODE_HOLD = 5'h06;
    localparam logic [4:0] MODE_HWCFG = 5'h07;
    localparam logic [4:0] MODE_OVR_REQ = 5'h08;
    localparam logic [4:0] MODE_OVR_EXEC = 5'h09;
    localparam logic [4:0] MODE_OVR_DONE = 5'h0A;
    localparam logic [4:0] MODE_FAC_EXEC = 5'h0B;
    localparam logic [4:0] MODE_FAC_DONE = 5'h0C;
    localparam logic [4:0] MODE_FW_AVAIL = 5'h0D;
    localparam logic [4:0] MODE_FW_UPDATE = 5'h0E;
    localparam logic [4:0] MODE_FW_OK = 5'h0F;
    localparam logic [4:0] MODE_FW_FAIL = 5'h10;
    // -------------------------------------------------------------------
    // channel counts
    // -------------------------------------------------------------------
    localparam int DI_W = 16;
    localparam int DO_W = 12;
    localparam int ETH_PORTS = 2;
    localparam int SYNC_W = DI_W + 6 + 3 * ETH_PORTS;
endpackage : sli_pkg

/* hdl/sli_timebase.sv */
// Purpose: shared divider for flicker, 2 Hz and 1 Hz phases
// Assumes: one clock, asynchronous active-low reset
// Notes: both blink phases change only on a flicker tick
`timescale 1ns/1ns
module sli_timebase
    import sli_pkg::*;
#(
    parameter int HALF_CYCLES = FLICKER_HALF_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    output logic tick,
    output logic flicker,
    output logic blink_2hz,
    output logic blink_1hz
);
    // -------------------------------------------------------------------
    // divider chain
    // -------------------------------------------------------------------
    logic [TB_CNT_W-1:0] cnt_reg;
    logic [FLK_CNT_W-1:0] flk_reg;
    logic flk_reg_out;
    logic b2_reg;
    logic b1_reg;
    wire cnt_end = (cnt_reg == TB_CNT_W'(HALF_CYCLES - 1));
    wire flk_end = (flk_reg == FLK_CNT_W'(FLICKS_PER_HALF - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= '0;
            flk_reg <= '0;
            flk_reg_out <= 1'b0;
            b2_reg <= 1'b0;
            b1_reg <= 1'b0;
        end else if (cnt_end) begin
            cnt_reg <= '0;
            flk_reg_out <= ~flk_reg_out; // RULE_24
            flk_reg <= flk_end ? '0 : flk_reg + 1'b1;
            if (flk_end) begin
                b2_reg <= ~b2_reg; // RULE_24
                if (b2_reg) begin
                    b1_reg <= ~b1_reg; // RULE_24
                end
            end
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end

    assign tick = cnt_end;
    assign flicker = flk_reg_out;
    assign blink_2hz = b2_reg;
    assign blink_1hz = b1_reg;
endmodule : sli_timebase

/* hdl/sli_led_driver.sv */
// Purpose: front panel status bar, channel and network LED driver
// Assumes: APB slave, zero wait states, pins other than do_level synchronised by two flip-flops
// Notes: mode and flags are written by the control logic; LEDs are registered
`timescale 1ns/1ns
module sli_led_driver
    import sli_pkg::*;
#(
    parameter int HALF_CYCLES = FLICKER_HALF_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [DI_W-1:0] di_level_pin,
    input wire logic [DO_W-1:0] do_level,
    input wire logic input_section_supply_ok,
    input wire logic output_section_supply_ok,
    input wire logic logic_section_supply_ok,
    input wire logic output_overload,
    input wire logic analog_channel_zero_range_err,
    input wire logic analog_channel_one_range_err,
    input wire logic [ETH_PORTS-1:0] eth_link,
    input wire logic [ETH_PORTS-1:0] eth_activity,
    input wire logic [ETH_PORTS-1:0] eth_speed100,
    output logic led_status_green,
    output logic led_status_yellow,
    output logic led_status_red,
    output logic [DI_W-1:0] led_di,
    output logic [DO_W-1:0] led_do,
    output logic led_input_supply,
    output logic led_output_supply,
    output logic led_logic_supply,
    output logic output_fault_indicator,
    output logic led_analog_zero,
    output logic led_analog_one,
    output logic [ETH_PORTS-1:0] led_eth_link,
    output logic [ETH_PORTS-1:0] led_eth_speed
);
    // -------------------------------------------------------------------
    // shared timebase
    // -------------------------------------------------------------------
    logic tick;
    logic flicker;
    logic blink_2hz;
    logic blink_1hz;

    sli_timebase #(
        .HALF_CYCLES(HALF_CYCLES)
    ) u_timebase (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick),
        .flicker(flicker),
        .blink_2hz(blink_2hz),
        .blink_1hz(blink_1hz)
    );

    // -------------------------------------------------------------------
    // pin synchronisers
    // -------------------------------------------------------------------
    logic [SYNC_W-1:0] sync1_reg;
    logic [SYNC_W-1:0] sync2_reg;
    wire [SYNC_W-1:0] pin_vec = {
        eth_speed100, eth_activity, eth_link,
        analog_channel_one_range_err, analog_channel_zero_range_err,
        output_overload, logic_section_supply_ok,
        output_section_supply_ok, input_section_supply_ok, di_level_pin
    };

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= pin_vec;
            sync2_reg <= sync1_reg;
        end
    end

    wire [ETH_PORTS-1:0] s_speed;
    wire [ETH_PORTS-1:0] s_act;
    wire [ETH_PORTS-1:0] s_link;
    wire s_ai1;
    wire s_ai0;
    wire s_ovl;
    wire s_lsup;
    wire s_osup;
    wire s_isup;
    wire [DI_W-1:0] s_di;

    assign {s_speed, s_act, s_link, s_ai1, s_ai0, s_ovl, s_lsup, s_osup, s_isup, s_di} =
        sync2_reg;

    // -------------------------------------------------------------------
    // apb slave
    // -------------------------------------------------------------------
    logic [MODE_W-1:0] mode_reg;
    logic [FLAGS_W-1:0] flags_reg;
    logic [31:0] prdata_reg;

    wire hit_mode = (paddr == ADDR_MODE);
    wire hit_flags = (paddr == ADDR_FLAGS);
    wire hit_led = (paddr == ADDR_LED);
    wire hit_input = (paddr == ADDR_INPUT);
    wire addr_hit = hit_mode | hit_flags | hit_led | hit_input;

    wire setup_rd = psel & ~penable & ~pwrite;
    wire access_wr = psel & penable & pwrite;
    wire wr_mode = access_wr & hit_mode;
    wire wr_flags = access_wr & hit_flags;

    wire [31:0] led_word = 32'({
        led_eth_speed, led_eth_link,
        led_status_red, led_status_yellow, led_status_green
    });
    wire [31:0] input_word = 32'({s_ai1, s_ai0, s_ovl, s_lsup, s_osup, s_isup, s_di});

    wire [31:0] rd_mux =
        hit_mode ? 32'(mode_reg) :
        hit_flags ? 32'(flags_reg) :
        hit_led ? led_word :
        hit_input ? input_word : 32'h0000_0000;

    assign pready = psel & penable;
    assign pslverr = psel & penable & ~addr_hit;
    assign prdata = prdata_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg <= MODE_POWER_ON; // RULE_01
            flags_reg <= FLAGS_RESET;
            prdata_reg <= '0;
        end else begin
            if (wr_mode) begin
                mode_reg <= pwdata[MODE_W-1:0];
            end
            if (wr_flags) begin
                flags_reg <= pwdata[FLAGS_W-1:0];
            end
            if (setup_rd) begin
                prdata_reg <= rd_mux;
            end
        end
    end

    wire errwarn = flags_reg[FLAG_ERRWARN];
    wire card = flags_reg[FLAG_CARD];
    wire blinktest = flags_reg[FLAG_BLINKTEST];
    wire diag = flags_reg[FLAG_DIAG];

    // -------------------------------------------------------------------
    // start-up minimum display time
    // -------------------------------------------------------------------
    logic [STARTUP_CNT_W-1:0] su_cnt_reg;
    logic was_startup_reg;

    wire in_startup_mode = (mode_reg == MODE_STARTUP);
    wire su_enter = in_startup_mode & ~was_startup_reg;
    wire su_hold = (su_cnt_reg != '0);

    wire show_startup = in_startup_mode | su_hold;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            su_cnt_reg <= '0;
            was_startup_reg <= 1'b0;
        end else begin
            was_startup_reg <= in_startup_mode;
            if (su_enter) begin
                su_cnt_reg <= STARTUP_CNT_W'(STARTUP_TICKS); // RULE_02
            end else if (tick && su_hold) begin
                su_cnt_reg <= su_cnt_reg - 1'b1; // RULE_02
            end
        end
    end

    // -------------------------------------------------------------------
    // status bar selection
    // -------------------------------------------------------------------
    logic st_r;
    logic st_y;
    logic st_g;

    always_comb begin
        st_r = 1'b0;
        st_y = 1'b0;
        st_g = 1'b0;

        if (show_startup) begin
            st_g = blink_2hz; // RULE_02
            st_r = diag & blink_1hz; // RULE_07
        end else begin
            case (mode_reg) // RULE_25
                MODE_POWER_ON: begin
                    st_y = blink_1hz; // RULE_01
                end

                MODE_HWCFG: begin
                    st_y = blink_2hz; // RULE_09
                end

                MODE_OVR_REQ: begin
                    st_y = blink_1hz; // RULE_13
                end

                MODE_OVR_EXEC: begin
                    st_y = blink_2hz; // RULE_13
                end

                MODE_OVR_DONE: begin
                    st_y = 1'b1; // RULE_13
                end

                MODE_FAC_EXEC: begin
                    st_y = blink_2hz; // RULE_14
                end

                MODE_FAC_DONE: begin
                    st_r = blink_1hz; // RULE_14
                    st_y = blink_1hz; // RULE_14
                end

                MODE_FW_AVAIL: begin
                    st_r = blink_1hz; // RULE_15
                    st_y = ~blink_1hz; // RULE_15
                end

                MODE_FW_UPDATE: begin
                    st_y = card ? flicker : blink_2hz; // RULE_16
                end

                MODE_FW_OK: begin
                    st_r = blink_1hz; // RULE_16
                    st_y = blink_1hz; // RULE_16
                end

                MODE_FW_FAIL: begin
                    st_r = blink_1hz; // RULE_16
                end

                MODE_ERROR: begin
                    st_r = 1'b1; // RULE_08
                end

                MODE_SYS_ERROR: begin
                    st_r = 1'b1; // RULE_08
                    st_y = 1'b1; // RULE_08
                end

                MODE_HOLD: begin
                    st_r = 1'b1; // RULE_06
                    st_g = blink_1hz; // RULE_06
                end

                MODE_RUN: begin
                    if (blinktest) begin
                        st_g = blink_1hz; // RULE_10
                    end else if (card) begin
                        st_r = errwarn & blink_1hz; // RULE_11
                        st_g = flicker; // RULE_11
                    end else if (errwarn) begin
                        st_r = blink_1hz; // RULE_05
                        st_g = 1'b1; // RULE_05
                    end else begin
                        st_g = 1'b1; // RULE_04
                    end
                end

                MODE_STOP: begin
                    if (blinktest) begin
                        st_g = blink_1hz; // RULE_10
                    end else if (card) begin
                        st_y = flicker; // RULE_12
                    end else begin
                        st_y = 1'b1; // RULE_03
                    end
                end

                default: begin
                    st_r = 1'b0;
                end
            endcase
        end
    end

    // -------------------------------------------------------------------
    // network activity stretch
    // -------------------------------------------------------------------
    logic [ETH_PORTS-1:0] act_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_reg <= '0;
        end else if (tick && !flicker) begin
            act_reg <= s_act;
        end else begin
            act_reg <= act_reg | s_act;
        end
    end

    wire [ETH_PORTS-1:0] eth_link_next = s_link & ~(act_reg & {ETH_PORTS{flicker}});

    // -------------------------------------------------------------------
    // output registers
    // -------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            led_status_green <= 1'b0;
            led_status_yellow <= 1'b0;
            led_status_red <= 1'b0;
            led_di <= '0;
            led_do <= '0;
            led_input_supply <= 1'b0;
            led_output_supply <= 1'b0;
            led_logic_supply <= 1'b0;
            output_fault_indicator <= 1'b0;
            led_analog_zero <= 1'b0;
            led_analog_one <= 1'b0;
            led_eth_link <= '0;
            led_eth_speed <= '0;

        end else begin
            led_status_green <= st_g;
            led_status_yellow <= st_y;
            led_status_red <= st_r;
            led_di <= s_di; // RULE_17
            led_do <= do_level; // RULE_18
            led_input_supply <= s_isup; // RULE_19
            led_output_supply <= s_osup; // RULE_20
            led_logic_supply <= s_lsup;
            output_fault_indicator <= s_ovl; // RULE_21
            led_analog_zero <= s_ai0; // RULE_22
            led_analog_one <= s_ai1; // RULE_22
            led_eth_link <= eth_link_next; // RULE_23
            led_eth_speed <= s_speed; // RULE_23
        end
    end
endmodule : sli_led_driver

/* sim/sli_panel_model.sv */
// Purpose: front panel lamp model for the status bar
// Assumes: a lamp is lit while its drive line is high
// Notes: lamp bit 0 green, bit 1 yellow, bit 2 red
`timescale 1ns/1ns
module sli_panel_model (
    input wire logic led_status_green,
    input wire logic led_status_yellow,
    input wire logic led_status_red,
    output logic [2:0] lamp
);
    assign lamp = {led_status_red, led_status_yellow, led_status_green};
endmodule : sli_panel_model

/* sim/sli_led_driver_props.sv */
// Purpose: port checks for the indicator driver
// Assumes: pins pass two sync stages and an output register; do_level passes the output register only
// Notes: bound into the driver
`timescale 1ns/1ns
module sli_led_driver_props
    import sli_pkg::*;
#(
    parameter int HALF_CYCLES = FLICKER_HALF_CYCLES
) (
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic [ADDR_W-1:0] paddr,
    input logic pready,
    input logic pslverr,
    input logic [DI_W-1:0] di_level_pin,
    input logic [DO_W-1:0] do_level,
    input logic input_section_supply_ok,
    input logic output_section_supply_ok,
    input logic output_overload,
    input logic analog_channel_zero_range_err,
    input logic analog_channel_one_range_err,
    input logic [ETH_PORTS-1:0] eth_link,
    input logic [ETH_PORTS-1:0] eth_speed100,
    input logic [DI_W-1:0] led_di,
    input logic [DO_W-1:0] led_do,
    input logic led_input_supply,
    input logic led_output_supply,
    input logic output_fault_indicator,
    input logic led_analog_zero,
    input logic led_analog_one,
    input logic [ETH_PORTS-1:0] led_eth_link,
    input logic [ETH_PORTS-1:0] led_eth_speed
);
    // ----
    // cycles since reset
    // ----
    logic [2:0] up_cnt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            up_cnt <= 3'h0;
        end else if (up_cnt != 3'h7) begin
            up_cnt <= up_cnt + 3'h1;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_zero_wait: assert property (pready == (psel && penable))
        else $error("pready wrong");
    a_err_unmapped: assert property (psel && penable && paddr > ADDR_INPUT |-> pslverr)
        else $error("no pslverr");
    a_di_follows: assert property (
        up_cnt == 3'h7 |-> led_di == $past(di_level_pin, 3)) else $error("di led wrong");
    a_do_follows: assert property (
        up_cnt != 3'h0 |-> led_do == $past(do_level)) else $error("do led wrong");
    a_in_supply: assert property (
        up_cnt == 3'h7 |-> led_input_supply == $past(input_section_supply_ok, 3))
        else $error("in supply led");
    a_out_supply: assert property (
        up_cnt == 3'h7 |-> led_output_supply == $past(output_section_supply_ok, 3))
        else $error("out supply led");
    a_fault_led: assert property (
        up_cnt == 3'h7 |-> output_fault_indicator == $past(output_overload, 3))
        else $error("fault led");
    a_analog_led: assert property (up_cnt == 3'h7 |->
        led_analog_zero == $past(analog_channel_zero_range_err, 3) &&
        led_analog_one == $past(analog_channel_one_range_err, 3)) else $error("ai led wrong");
    a_eth_speed: assert property (
        up_cnt == 3'h7 |-> led_eth_speed == $past(eth_speed100, 3)) else $error("speed led");
    a_link_dark: assert property (
        up_cnt == 3'h7 && $past(eth_link, 3) == 2'h0 |-> led_eth_link == 2'h0)
        else $error("link led lit");
endmodule : sli_led_driver_props
bind sli_led_driver sli_led_driver_props #(.HALF_CYCLES(HALF_CYCLES)) u_props (.*);

/* sim/tb_top.sv */
// Purpose: self-checking bench for the indicator driver
// Assumes: HALF_CYCLES of 4, so 1 Hz half period is 40 cycles
// Notes: rates judged by toggle counts
`timescale 1ns/1ns
module tb_top
    import sli_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [DI_W-1:0] di_level_pin, led_di;
    logic [DO_W-1:0] do_level, led_do;
    logic input_section_supply_ok, output_section_supply_ok, logic_section_supply_ok;
    logic output_overload, analog_channel_zero_range_err, analog_channel_one_range_err;
    logic [ETH_PORTS-1:0] eth_link, eth_activity, eth_speed100, led_eth_link, led_eth_speed;
    logic led_status_green, led_status_yellow, led_status_red, led_input_supply;
    logic led_output_supply, led_logic_supply, output_fault_indicator;
    logic led_analog_zero, led_analog_one;
    logic [2:0] lamp, lv;
    int n_errors, samples_checked, eq;
    int tg[3];
    sli_led_driver #(.HALF_CYCLES(4)) uut (.*);
    sli_panel_model u_panel (.*);
    always #25 pclk = ~pclk;
    // ----
    // shared tasks
    // ----
    task final_report;
        if (n_errors == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : final_report
    task check(input string nm, input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
        end
    endtask : check
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            n_errors++;
            final_report;
        end
    endtask : apb
    task watch;
        logic [2:0] prev;
        int i, k;
        repeat (2) @(posedge pclk);
        prev = lamp;
        eq = (lamp[2] === lamp[1]);
        tg = '{0, 0, 0};
        for (i = 0; i < 160; i++) begin
            @(posedge pclk);
            for (k = 0; k < 3; k++) if (lamp[k] !== prev[k]) tg[k]++;
            if (lamp[2] === lamp[1]) eq++;
            prev = lamp;
        end
        lv = lamp;
    endtask : watch
    function logic [31:0] obs(input int k);
        return (tg[k] == 0) ? {31'h0, lv[k]} : tg[k];
    endfunction : obs
    // ----
    // scenarios
    // ----
    task rc(input logic [4:0] m, input logic [3:0] f, input int g, y, r, e);
        apb(1'b1, ADDR_FLAGS, 32'(f));
        apb(1'b1, ADDR_MODE, 32'(m));
        watch;
        check("green", obs(0), g);
        check("yellow", obs(1), y);
        check("red", obs(2), r);
        if (e >= 0) check("phase", eq, e);
    endtask : rc
    task test_regs;
        apb(1'b0, ADDR_MODE, 32'h0);
        check("mode_rst", rd, 32'(MODE_POWER_ON));
        apb(1'b0, ADDR_FLAGS, 32'h0);
        check("flags_rst", rd, 32'(FLAGS_RESET));
        apb(1'b1, ADDR_FLAGS, 32'hFFFFFFFF);
        apb(1'b0, ADDR_FLAGS, 32'h0);
        check("flags_rw", rd, 32'h0000000F);
        apb(1'b0, 12'h010, 32'h0);
        check("unmapped_err", 32'(er), 32'h1);
        check("unmapped_rd", rd, 32'h0);
    endtask : test_regs
    task test_startup;
        apb(1'b1, ADDR_FLAGS, 32'h8);
        apb(1'b1, ADDR_MODE, 32'(MODE_STARTUP));
        apb(1'b1, ADDR_MODE, 32'(MODE_RUN));
        watch;
        check("startup_green", obs(0), 8);
        check("diag_red", obs(2), 4);
        repeat (STARTUP_TICKS * 4) @(posedge pclk);
    endtask : test_startup
    task test_pins(input logic [15:0] p);
        @(posedge pclk);
        di_level_pin <= p;
        do_level <= p[11:0];
        {analog_channel_one_range_err, analog_channel_zero_range_err, output_overload,
            logic_section_supply_ok, output_section_supply_ok, input_section_supply_ok} <= p[5:0];
        repeat (4) @(posedge pclk);
        check("led_di", 32'(led_di), 32'(p));
        check("led_do", 32'(led_do), 32'(p[11:0]));
        check("in_sup", 32'(led_input_supply), 32'(p[0]));
        check("out_sup", 32'(led_output_supply), 32'(p[1]));
        check("logic_sup", 32'(led_logic_supply), 32'(p[2]));
        check("fault", 32'(output_fault_indicator), 32'(p[3]));
        check("analog", 32'({led_analog_one, led_analog_zero}), 32'(p[5:4]));
        apb(1'b0, ADDR_INPUT, 32'h0);
        check("input_reg", rd, {10'h0, p[5:0], p});
    endtask : test_pins
    task test_eth;
        int n, dark;
        @(posedge pclk);
        eth_link <= 2'h3;
        eth_speed100 <= 2'h2;
        repeat (5) @(posedge pclk);
        check("link", 32'(led_eth_link), 32'h3);
        check("speed", 32'(led_eth_speed), 32'h2);
        eth_activity <= 2'h1;
        dark = 0;
        for (n = 0; n < 40; n++) begin
            @(posedge pclk);
            if (led_eth_link === 2'h2) dark++;
        end
        check("activity", 32'(dark != 0), 32'h1);
        eth_activity <= 2'h0;
        eth_link <= 2'h0;
        repeat (5) @(posedge pclk);
        check("no_link", 32'(led_eth_link), 32'h0);
    endtask : test_eth
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {di_level_pin, do_level, eth_link, eth_activity, eth_speed100} = '0;
        {input_section_supply_ok, output_section_supply_ok, logic_section_supply_ok} = 3'h7;
        {output_overload, analog_channel_zero_range_err, analog_channel_one_range_err} = 3'h0;
        n_errors = 0;
        samples_checked = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        test_regs;
        rc(MODE_POWER_ON, 4'h0, 0, 4, 0, -1);
        test_startup;
        rc(MODE_RUN, 4'h0, 1, 0, 0, -1);
        rc(MODE_RUN, 4'h1, 1, 0, 4, -1);
        rc(MODE_STOP, 4'h0, 0, 1, 0, -1);
        rc(MODE_HOLD, 4'h0, 4, 0, 1, -1);
        rc(MODE_ERROR, 4'h0, 0, 0, 1, -1);
        rc(MODE_SYS_ERROR, 4'h2, 0, 1, 1, 161);
        rc(MODE_HWCFG, 4'h0, 0, 8, 0, -1);
        rc(MODE_RUN, 4'h4, 4, 0, 0, -1);
        rc(MODE_RUN, 4'h2, 40, 0, 0, -1);
        rc(MODE_RUN, 4'h3, 40, 0, 4, -1);
        rc(MODE_STOP, 4'h2, 0, 40, 0, -1);
        rc(MODE_OVR_REQ, 4'h0, 0, 4, 0, -1);
        rc(MODE_OVR_EXEC, 4'h0, 0, 8, 0, -1);
        rc(MODE_OVR_DONE, 4'h0, 0, 1, 0, -1);
        rc(MODE_FAC_EXEC, 4'h0, 0, 8, 0, -1);
        rc(MODE_FAC_DONE, 4'h0, 0, 4, 4, 161);
        rc(MODE_FW_AVAIL, 4'h0, 0, 4, 4, 0);
        rc(MODE_FW_UPDATE, 4'h0, 0, 8, 0, -1);
        rc(MODE_FW_UPDATE, 4'h2, 0, 40, 0, -1);
        rc(MODE_FW_OK, 4'h0, 0, 4, 4, 161);
        rc(MODE_FW_FAIL, 4'h0, 0, 0, 4, -1);
        rc(MODE_ERROR, 4'h2, 0, 0, 1, -1);
        rc(MODE_FW_UPDATE, 4'h1, 0, 8, 0, -1);
        rc(5'h11, 4'h0, 0, 0, 0, -1);
        test_pins(16'hA5C3);
        test_pins(16'h5A3C);
        test_eth;
        final_report;
    end
endmodule : tb_top
